/* common/vme_bridge_regs.vh */
// Constants for the VME host bridge: decode ranges, modifiers, timing
`ifndef VME_BRIDGE_REGS_VH
`define VME_BRIDGE_REGS_VH

// ==========================================================
// Address modifier codes
`define AM_A32_NP_DATA 6'h09
`define AM_A32_SV_DATA 6'h0D
`define AM_A24_NP_DATA 6'h39
`define AM_A24_SV_DATA 6'h3D
`define AM_A16_NP      6'h29
`define AM_A16_SV      6'h2D
`define AM_A32_NP_BLT  6'h0B
`define AM_A32_SV_BLT  6'h0F
`define AM_A24_NP_BLT  6'h3B
`define AM_A24_SV_BLT  6'h3F

// ==========================================================
// Local memory limits
`define LOCAL_MEM_MAX   32'h06000000
`define A24_LOW_WINDOW  24'h800000

// ==========================================================
// Timing
`define CLK_PERIOD_NS   5
`define WDOG_TIME_NS    32000
`define WDOG_CYCLES     (`WDOG_TIME_NS / `CLK_PERIOD_NS)
`define SYSCLK_HZ       16000000
`define CORE_HZ         200000000
`define SYSCLK_HALF_DIV (`CORE_HZ / (2 * `SYSCLK_HZ))

`endif

/* src/bridge_sync2.v */
// Two-flop synchroniser for a group of static inputs
`timescale 1ns/1ps
module bridge_sync2 #(
	parameter WIDTH = 1
) (
	input  wire             core_clk_in,
	input  wire             rst_in,
	input  wire [WIDTH-1:0] async_in,
	output reg  [WIDTH-1:0] sync_out
);
	reg [WIDTH-1:0] meta_r;

	always @(posedge core_clk_in) begin
		if (rst_in) begin
			meta_r   <= {WIDTH{1'b0}};
			sync_out <= {WIDTH{1'b0}};
		end else begin
			meta_r   <= async_in;
			sync_out <= meta_r;
		end
	end
endmodule

/* src/vme_host_interface.v */
// VME host bridge: master decode, slave decode, arbiter, clock, watchdog
// Function
// R1: 0x10-0x1B becomes A32 non-priv, nibble 1
// R2: 0x1C range is A24 supervisory data
// R3: 0x1E range is A24 non-privileged data
// R4: 0x1D0 range is A16 supervisory
// R5: 0x1D1 range is A16 non-privileged
// R6: 0x1DF range issues IACK cycles
// R7: 0x1D2-0x1DE aliases A16 or IACK
// R8: 0x2/0x3 ranges A32, top nibble zero
// R9: D32/16/8 and RMW; no block transfers
// R10: Request on level three, release when done
// R11: Slave accepts single and block, aligned only
// R12: Slave RMW accepted, not atomic
// R13: A32 slave: A31 zero, A30:28 switches
// R14: A24 low 8 MB; 4 MB windows non-priv
// R15: Switch disables all A24 slave responses
// R16: Round-robin VME versus graphics DMA
// R17: Illegal reads bus error, writes interrupt; illegal slave writes get DTACK and raise no interrupt
// R18: Beyond installed memory below 256 MB illegal
// R19: Single-level arbiter on level three, daisy chain
// R20: Others must not request levels zero-two
// R21: Drive 16 MHz system clock; divider gives 200 MHz / 12, about 16.7 MHz
// R22: Watchdog expires after 32 us
// R23: Slave disabled ignores all VME accesses
// R24: Arbiter disable bit selects external arbiter
// R25: RMW flag high during RMW cycle
// R26: Watchdog expiry errors read, interrupts write
// R27: Switches synchronised before slave decode
`timescale 1ns/1ps
`include "vme_bridge_regs.vh"
module vme_host_interface #(
	parameter WDOG_COUNT = `WDOG_CYCLES
) (
	input  wire        core_clk_in,
	input  wire        rst_in,
	// Local master request
	input  wire        loc_req_in,
	input  wire        loc_write_in,
	input  wire        loc_rmw_in,
	input  wire [31:0] loc_addr_in,
	input  wire [1:0]  loc_size_in,
	input  wire [31:0] loc_wdata_in,
	output reg         loc_done_out,
	output reg         loc_berr_out,
	output reg  [31:0] loc_rdata_out,
	output reg         write_err_irq_out,
	// Control and status
	input  wire        vme_slave_enable_in,
	input  wire        arbiter_disable_in,
	input  wire [31:0] mem_size_in,
	input  wire [1:0]  a24_window_in,
	input  wire [2:0]  a32_switch_in,
	input  wire        a24_disable_switch_in,
	output reg         rmw_cycle_flag_out,
	// VME master pins
	output reg  [31:0] vme_addr_out,
	output reg  [5:0]  vme_am_out,
	output reg  [1:0]  vme_size_out,
	output reg         vme_write_out,
	output reg         vme_as_out,
	output reg         vme_iack_out,
	output reg         vme_br3_out,
	input  wire        vme_bg3_in,
	input  wire        vme_dtack_in,
	input  wire        vme_berr_in,
	input  wire [31:0] vme_rdata_in,
	output reg  [31:0] vme_wdata_out,
	// Arbiter and system controller
	input  wire        vme_br3_bus_in,
	input  wire        vme_bbsy_in,
	output reg         vme_bg3_out,
	output reg         vme_sysclk_out,
	// VME slave pins
	input  wire        slv_as_in,
	input  wire [31:0] slv_addr_in,
	input  wire [5:0]  slv_am_in,
	input  wire        slv_aligned_in,
	input  wire        slv_write_in,
	output reg         slv_dtack_out,
	output reg         slv_berr_out,
	// Local memory port shared with graphics DMA
	input  wire        gdma_req_in,
	output reg         gdma_grant_out,
	output reg         mem_req_out,
	output reg  [31:0] mem_addr_out,
	output reg         mem_write_out,
	input  wire        mem_ack_in
);
	localparam M_IDLE = 2'h0;
	localparam M_REQ  = 2'h1;
	localparam M_XFER = 2'h2;
	localparam M_END  = 2'h3;

	// ==========================================================
	// Pin synchronisers
	wire [8:0] pin_s;
	wire [4:0] sw_s;
	reg  [1:0] a24w_r;

	bridge_sync2 #(.WIDTH(9)) u_pin_sync (
		.core_clk_in (core_clk_in),
		.rst_in      (rst_in),
		.async_in    ({vme_bg3_in, vme_dtack_in, vme_berr_in,
		               vme_br3_bus_in, vme_bbsy_in, slv_as_in,
		               slv_aligned_in, slv_write_in, gdma_req_in}),
		.sync_out    (pin_s)
	);
	bridge_sync2 #(.WIDTH(5)) u_sw_sync ( // see R27
		.core_clk_in (core_clk_in),
		.rst_in      (rst_in),
		.async_in    ({a32_switch_in, a24_disable_switch_in,
		               vme_slave_enable_in}),
		.sync_out    (sw_s)
	);
	wire bg3_s   = pin_s[8];
	wire dtack_s = pin_s[7];
	wire berr_s  = pin_s[6];
	wire br3b_s  = pin_s[5];
	wire bbsy_s  = pin_s[4];
	wire sas_s   = pin_s[3];
	wire salgn_s = pin_s[2];
	wire swr_s   = pin_s[1];
	wire gdma_s  = pin_s[0];

	always @(posedge core_clk_in) begin
		if (rst_in)
			a24w_r <= 2'h0;
		else
			a24w_r <= a24_window_in;
	end

	// ==========================================================
	// Master address decode
	reg        dec_ok;
	reg        dec_iack;
	reg [5:0]  dec_am;
	reg [31:0] dec_addr;
	wire [7:0] top = loc_addr_in[31:24];
	wire [3:0] sub = loc_addr_in[23:20];

	always @* begin
		dec_ok   = 1'b1;
		dec_iack = 1'b0;
		dec_am   = `AM_A32_NP_DATA;
		dec_addr = loc_addr_in;
		if (top >= 8'h10 && top <= 8'h1B) begin
			dec_addr = {4'h1, loc_addr_in[27:0]}; // see R1
		end else if (top == 8'h1C) begin
			dec_am   = `AM_A24_SV_DATA; // see R2
			dec_addr = {8'h00, loc_addr_in[23:0]};
		end else if (top == 8'h1E) begin
			dec_am   = `AM_A24_NP_DATA; // see R3
			dec_addr = {8'h00, loc_addr_in[23:0]};
		end else if (top == 8'h1D) begin
			// Only bit 20 and the IACK nibble decode; the middle aliases
			dec_addr = {16'h0000, loc_addr_in[15:0]}; // see R7
			if (sub == 4'hF) begin
				dec_iack = 1'b1; // see R6
				dec_am   = `AM_A16_SV;
				dec_addr = {29'h0, loc_addr_in[3:1]};
			end else if (loc_addr_in[20])
				dec_am = `AM_A16_NP; // see R5
			else
				dec_am = `AM_A16_SV; // see R4
		end else if (top[7:4] == 4'h2) begin
			dec_addr = {4'h0, loc_addr_in[27:0]}; // see R8
		end else if (top[7:4] == 4'h3) begin
			dec_am   = `AM_A32_SV_DATA; // see R8
			dec_addr = {4'h0, loc_addr_in[27:0]};
		end else begin
			dec_ok = 1'b0; // see R17
		end
	end

	// Unaligned sizes never issue: halfword needs bit0 clear, word bits 1:0
	wire aligned = (loc_size_in == 2'h2) ? (loc_addr_in[1:0] == 2'h0) :
	               (loc_size_in == 2'h1) ? ~loc_addr_in[0] : 1'b1;

	// ==========================================================
	// Master sequencer with watchdog
	reg [1:0]  mst_r;
	reg [15:0] wdog_r;
	reg        rmw_hold_r;
	reg        rmw_gap_r;
	wire       wdog_exp = (wdog_r == WDOG_COUNT[15:0]); // see R22

	always @(posedge core_clk_in) begin
		if (rst_in) begin
			mst_r              <= M_IDLE;
			wdog_r             <= 16'h0000;
			rmw_hold_r         <= 1'b0;
			rmw_gap_r          <= 1'b0;
			loc_done_out       <= 1'b0;
			loc_berr_out       <= 1'b0;
			loc_rdata_out      <= 32'h00000000;
			write_err_irq_out  <= 1'b0;
			rmw_cycle_flag_out <= 1'b0;
			vme_addr_out       <= 32'h00000000;
			vme_am_out         <= 6'h00;
			vme_size_out       <= 2'h0;
			vme_write_out      <= 1'b0;
			vme_as_out         <= 1'b0;
			vme_iack_out       <= 1'b0;
			vme_br3_out        <= 1'b0;
			vme_wdata_out      <= 32'h00000000;
		end else begin
			loc_done_out      <= 1'b0;
			loc_berr_out      <= 1'b0;
			write_err_irq_out <= 1'b0;
			rmw_gap_r         <= rmw_gap_r & dtack_s; // see R9
			if (mst_r == M_IDLE)
				wdog_r <= 16'h0000;
			else if (!wdog_exp)
				wdog_r <= wdog_r + 16'h0001;
			case (mst_r)
			M_IDLE: begin
				if (loc_req_in) begin
					if (!dec_ok || !aligned) begin
						loc_done_out      <= 1'b1; // see R17
						loc_berr_out      <= ~loc_write_in;
						write_err_irq_out <= loc_write_in;
					end else begin
						vme_addr_out  <= dec_addr;
						vme_am_out    <= dec_am; // see R9
						vme_size_out  <= dec_iack ? 2'h0 : loc_size_in;
						vme_write_out <= loc_write_in & ~dec_iack & ~loc_rmw_in;
						vme_iack_out  <= dec_iack;
						vme_wdata_out <= loc_wdata_in;
						rmw_hold_r    <= loc_rmw_in & ~dec_iack;
						vme_br3_out   <= 1'b1; // see R10
						mst_r         <= M_REQ;
					end
				end
			end
			M_REQ: begin
				if (wdog_exp)
					mst_r <= M_END;
				else if (bg3_s && !bbsy_s) begin
					vme_as_out         <= 1'b1;
					rmw_cycle_flag_out <= rmw_hold_r; // see R25
					mst_r              <= M_XFER;
				end
			end
			M_XFER: begin
				if (dtack_s && rmw_hold_r && !vme_write_out) begin
					// RMW: keep the bus, turn the read into a write
					loc_rdata_out <= vme_rdata_in;
					vme_write_out <= 1'b1;
					rmw_hold_r    <= 1'b0;
					rmw_gap_r     <= 1'b1;
				end else if ((dtack_s && !rmw_gap_r) || berr_s || wdog_exp) begin
					if (!vme_write_out)
						loc_rdata_out <= vme_rdata_in;
					loc_done_out      <= 1'b1;
					loc_berr_out      <= (berr_s | wdog_exp) & ~vme_write_out;
					write_err_irq_out <= (berr_s | wdog_exp) & vme_write_out;
					vme_as_out         <= 1'b0;
					vme_br3_out        <= 1'b0; // see R10
					rmw_cycle_flag_out <= 1'b0; // see R25
					mst_r              <= M_IDLE;
				end
			end
			M_END: begin
				loc_done_out      <= 1'b1; // see R26
				loc_berr_out      <= ~vme_write_out;
				write_err_irq_out <= vme_write_out;
				vme_as_out        <= 1'b0;
				vme_br3_out       <= 1'b0;
				mst_r             <= M_IDLE;
			end
			default: mst_r <= M_IDLE;
			endcase
		end
	end

	// ==========================================================
	// Single-level arbiter and system clock
	reg [3:0] clkdiv_r;

	always @(posedge core_clk_in) begin
		if (rst_in) begin
			vme_bg3_out    <= 1'b0;
			vme_sysclk_out <= 1'b0;
			clkdiv_r       <= 4'h0;
		end else begin
			if (arbiter_disable_in) // see R24
				vme_bg3_out <= 1'b0;
			else // Only level three is watched; lower levels never granted
				vme_bg3_out <= br3b_s & ~bbsy_s; // see R19
			if ({28'h0000000, clkdiv_r} == `SYSCLK_HALF_DIV - 1) begin
				clkdiv_r       <= 4'h0;
				vme_sysclk_out <= ~vme_sysclk_out; // see R21
			end else
				clkdiv_r <= clkdiv_r + 4'h1;
		end
	end

	// ==========================================================
	// Slave decode
	wire [5:0] sam   = slv_am_in;
	wire       s_a32 = (sam == `AM_A32_NP_DATA) || (sam == `AM_A32_SV_DATA) ||
	                   (sam == `AM_A32_NP_BLT) || (sam == `AM_A32_SV_BLT);
	wire       s_a24 = (sam == `AM_A24_NP_DATA) || (sam == `AM_A24_SV_DATA) ||
	                   (sam == `AM_A24_NP_BLT) || (sam == `AM_A24_SV_BLT);
	wire       s_np  = ~sam[2];
	wire       hit32 = s_a32 && !slv_addr_in[31] &&
	                   (slv_addr_in[30:28] == sw_s[4:2]); // see R13
	wire       low24 = slv_addr_in[23:0] < `A24_LOW_WINDOW;
	// Upper half of A24 maps a 4 MB window chosen by the window select
	wire       hit24 = s_a24 && !sw_s[1] && (low24 || s_np); // see R14 R15
	wire [31:0] loc24 = low24 ? {8'h00, slv_addr_in[23:0]} :
	                    {6'h00, a24w_r, 2'h0, slv_addr_in[21:0]};
	wire [31:0] s_loc = hit32 ? {4'h0, slv_addr_in[27:0]} : loc24;
	wire        s_hit = (hit32 || hit24) && salgn_s && sw_s[0]; // see R11 R23

	// ==========================================================
	// Memory port, round-robin with graphics DMA
	reg s_busy_r;
	reg last_vme_r;
	reg g_busy_r;

	always @(posedge core_clk_in) begin
		if (rst_in) begin
			s_busy_r       <= 1'b0;
			g_busy_r       <= 1'b0;
			last_vme_r     <= 1'b0;
			slv_dtack_out  <= 1'b0;
			slv_berr_out   <= 1'b0;
			gdma_grant_out <= 1'b0;
			mem_req_out    <= 1'b0;
			mem_addr_out   <= 32'h00000000;
			mem_write_out  <= 1'b0;
		end else begin
			if (!sas_s) begin
				slv_dtack_out <= 1'b0;
				slv_berr_out  <= 1'b0;
			end
			if (s_busy_r || g_busy_r) begin
				if (mem_ack_in) begin
					mem_req_out    <= 1'b0;
					s_busy_r       <= 1'b0;
					g_busy_r       <= 1'b0;
					gdma_grant_out <= 1'b0;
					slv_dtack_out  <= s_busy_r;
				end
			end else if (sas_s && !slv_dtack_out && !slv_berr_out && s_hit &&
			             (!gdma_s || !last_vme_r)) begin // see R16
				if (s_loc >= mem_size_in || s_loc >= `LOCAL_MEM_MAX) begin
					slv_berr_out <= ~swr_s; // see R17 R18
					slv_dtack_out <= swr_s;
				end else begin
					// Each RMW phase is a separate grant, so DMA may
					// slip in between them
					s_busy_r      <= 1'b1; // see R12
					last_vme_r    <= 1'b1;
					mem_req_out   <= 1'b1;
					mem_addr_out  <= s_loc;
					mem_write_out <= swr_s;
				end
			end else if (gdma_s) begin
				g_busy_r       <= 1'b1;
				last_vme_r     <= 1'b0;
				gdma_grant_out <= 1'b1;
				mem_req_out    <= 1'b1;
				mem_write_out  <= 1'b0;
			end
		end
	end
endmodule

/* sim/vme_bridge_checker.sv */
// Concurrent checks on the VME host bridge ports
`timescale 1ns/1ps
`include "vme_bridge_regs.vh"
module vme_bridge_checker #(
	parameter WDOG_COUNT = 6400
) (
	input logic        core_clk_in,
	input logic        rst_in,
	input logic        loc_write_in,
	input logic        loc_rmw_in,
	input logic [31:0] loc_addr_in,
	input logic        loc_done_out,
	input logic        loc_berr_out,
	input logic        vme_slave_enable_in,
	input logic        arbiter_disable_in,
	input logic        vme_br3_bus_in,
	input logic        vme_bbsy_in,
	input logic        vme_bg3_out,
	input logic        vme_sysclk_out,
	input logic        rmw_cycle_flag_out,
	input logic [31:0] vme_addr_out,
	input logic [5:0]  vme_am_out,
	input logic        vme_as_out,
	input logic        vme_iack_out,
	input logic        vme_br3_out,
	input logic        slv_dtack_out
);
	// ==========================================================
	// Helpers
	wire [7:0]   t = loc_addr_in[31:24];
	logic [15:0] wd_r;
	always @(posedge core_clk_in) begin
		wd_r <= (rst_in || !vme_br3_out) ? 16'h0 : wd_r + 16'h1;
	end
	default clocking @(posedge core_clk_in); endclocking
	default disable iff (rst_in);
	// ==========================================================
	// Master decode, bus ownership, slave enable and system clock
	a32_np_map_a: assert property (
		vme_as_out && t >= 8'h10 && t <= 8'h1B |->
		vme_am_out == `AM_A32_NP_DATA && vme_addr_out[31:28] == 4'h1)
		else $error("A32 window map wrong");
	a24_map_a: assert property (
		vme_as_out && (t == 8'h1C || t == 8'h1E) |-> vme_am_out ==
		(t[1] ? `AM_A24_NP_DATA : `AM_A24_SV_DATA)) else $error("A24 wrong");
	a16_map_a: assert property (
		vme_as_out && t == 8'h1D && loc_addr_in[23:21] == 3'h0 |->
		vme_am_out == (loc_addr_in[20] ? `AM_A16_NP : `AM_A16_SV))
		else $error("A16 map wrong");
	iack_map_a: assert property (
		vme_as_out && loc_addr_in[31:20] == 12'h1DF |-> vme_iack_out)
		else $error("IACK cycle missing");
	a32_low_a: assert property (
		vme_as_out && t[7:5] == 3'h1 |-> vme_addr_out[31:28] == 4'h0 &&
		vme_am_out == (t[4] ? `AM_A32_SV_DATA : `AM_A32_NP_DATA))
		else $error("low A32 map wrong");
	rwd_hold_a: assert property (vme_as_out |-> vme_br3_out)
		else $error("strobe without request");
	bad_read_a: assert property (
		loc_done_out && !loc_write_in && t >= 8'h40 |-> loc_berr_out)
		else $error("illegal read not errored");
	wdog_bound_a: assert property (wd_r <= WDOG_COUNT + 2)
		else $error("transfer outlived watchdog");
	slave_off_a: assert property (
		$rose(slv_dtack_out) |-> $past(vme_slave_enable_in, 4))
		else $error("disabled slave answered");
	arb_grant_a: assert property (
		(vme_br3_bus_in && !vme_bbsy_in && !arbiter_disable_in) [*4]
		|-> vme_bg3_out) else $error("grant missing");
	arb_off_a: assert property (arbiter_disable_in [*3] |-> !vme_bg3_out)
		else $error("disabled arbiter granted");
	rmw_flag_a: assert property (
		vme_as_out && $past(vme_as_out) && loc_rmw_in |-> rmw_cycle_flag_out)
		else $error("RMW flag low");
	sysclk_half_a: assert property (
		$changed(vme_sysclk_out) |=> $stable(vme_sysclk_out) [*5]
		##1 $changed(vme_sysclk_out)) else $error("system clock rate off");
endmodule
bind vme_host_interface vme_bridge_checker #(.WDOG_COUNT(WDOG_COUNT))
	vme_bridge_checker_i (.*);

/* sim/vme_far_side.sv */
// Behavioural backplane slave and grant source facing the bridge master
`timescale 1ns/1ps
module vme_far_side (
	input  logic        core_clk_in,
	input  logic        rst_in,
	input  logic        as_in,
	input  logic        br3_in,
	input  logic        mute_in,
	input  logic        slow_in,
	input  logic [31:0] addr_in,
	output logic        dtack_out,
	output logic        bg3_out,
	output logic [31:0] rdata_out
);
	logic [6:0] cnt_r;
	logic [2:0] bg_r;
	always @(posedge core_clk_in) begin
		cnt_r <= as_in ? cnt_r + 7'h01 : 7'h00;
		bg_r  <= rst_in ? 3'h0 : {bg_r[1:0], br3_in};
	end
	// Grants answer level three requests only
	assign bg3_out = bg_r[2];
	// Acknowledge repeats while strobed, so an RMW pair sees two phases
	assign dtack_out = as_in && !mute_in &&
		(slow_in ? &cnt_r[6:4] : &cnt_r[3:2]);
	// Released lines show the inverse so stale data cannot pass
	assign rdata_out = {32{dtack_out}} ~^ (addr_in ^ 32'h5A5A5A5A);
endmodule

/* sim/testbench.sv */
// Self-checking bench for the VME host bridge
`timescale 1ns/1ps
`include "vme_bridge_regs.vh"
`define CHK(g, e) begin tests_run++; if ((g) !== (e)) begin fail_count++; \
	$display("BAD t=%0t got %h exp %h", $time, g, e); end end
module testbench;
	logic core_clk_in = 0, rst_in = 1, loc_req_in = 0, loc_write_in = 0;
	logic loc_rmw_in = 0, vme_slave_enable_in = 1, arbiter_disable_in = 0;
	logic a24_disable_switch_in = 0, vme_br3_bus_in = 0, vme_bbsy_in = 0;
	logic slv_as_in = 0, slv_aligned_in = 1, slv_write_in = 0, mute = 0;
	logic gdma_req_in = 0, mem_ack_in = 0, vme_berr_in = 0, slow = 0;
	logic [31:0] loc_addr_in = 0, loc_wdata_in = 0, slv_addr_in = 0;
	logic [31:0] mem_size_in = 32'h02000000;
	logic [1:0]  loc_size_in = 0, a24_window_in = 0;
	logic [2:0]  a32_switch_in = 3'h5;
	logic [5:0]  slv_am_in = 0;
	wire loc_done_out, loc_berr_out, write_err_irq_out, rmw_cycle_flag_out;
	wire vme_write_out, vme_as_out, vme_iack_out, vme_br3_out, vme_bg3_in;
	wire vme_dtack_in, vme_bg3_out, vme_sysclk_out, slv_dtack_out;
	wire slv_berr_out, gdma_grant_out, mem_req_out, mem_write_out;
	wire [31:0] loc_rdata_out, vme_addr_out, vme_wdata_out, vme_rdata_in;
	wire [31:0] mem_addr_out;
	wire [5:0]  vme_am_out;
	wire [1:0]  vme_size_out;
	integer seed = 11, fail_count = 0, tests_run = 0, cyc = 0;
	// Watchdog shortened so stalled transfers end quickly
	vme_host_interface #(.WDOG_COUNT(200)) vme_host_interface_i (.*);
	vme_far_side vme_far_side_i (.core_clk_in(core_clk_in),
		.rst_in(rst_in), .as_in(vme_as_out), .br3_in(vme_br3_out),
		.mute_in(mute), .slow_in(slow), .addr_in(vme_addr_out),
		.dtack_out(vme_dtack_in), .bg3_out(vme_bg3_in),
		.rdata_out(vme_rdata_in));
	// ==========================================================
	// Clock, memory and graphics DMA traffic, time limit
	always #2.5 core_clk_in = ~core_clk_in;
	always @(posedge core_clk_in) begin
		mem_ack_in <= #1 mem_req_out & ~mem_ack_in;
		gdma_req_in <= #1 $random(seed) & 1;
		cyc++;
		if (cyc == 20000) begin
			fail_count++;
			give_verdict;
		end
	end
	task give_verdict;
		$display("comparisons %0d mismatches %0d", tests_run, fail_count);
		if (fail_count == 0 && tests_run > 0)
			$display("Test passed");
		else
			$display("Test failed");
		$finish;
	endtask
	// ==========================================================
	// Reference decode
	function [5:0] xam(input [31:0] a);
		case (a[31:24])
			8'h1C: xam = `AM_A24_SV_DATA;
			8'h1E: xam = `AM_A24_NP_DATA;
			8'h1D: xam = a[20] ? `AM_A16_NP : `AM_A16_SV;
			default: xam = (a[31:28] == 4'h3) ? `AM_A32_SV_DATA :
				`AM_A32_NP_DATA;
		endcase
	endfunction
	function [31:0] xva(input [31:0] a);
		case (a[31:24])
			8'h1C, 8'h1E: xva = {8'h00, a[23:0]};
			8'h1D: xva = {16'h0000, a[15:0]};
			default: xva = {(a[31:28] == 4'h1) ? 4'h1 : 4'h0, a[27:0]};
		endcase
	endfunction
	task m(input [31:0] a, input w, input r);
		integer i;
		reg sa, ia, wr, rf, irq, ill, ik;
		reg [5:0] am;
		reg [31:0] va;
		begin
			@(posedge core_clk_in);
			#1;
			loc_addr_in = a; loc_write_in = w; loc_rmw_in = r;
			// Acknowledge cycles are byte wide
			loc_size_in = r ? 2'h2 : (a[31:20] == 12'h1DF) ? 2'h0 :
				$unsigned($random(seed)) % 3;
			loc_wdata_in = $random(seed); loc_req_in = 1;
			{sa, rf, irq} = 0;
			for (i = 0; i < 400 && loc_done_out !== 1; i++) begin
				@(posedge core_clk_in);
				#1;
				if (vme_as_out === 1 && !sa) begin
					{sa, ia, wr} = {1'b1, vme_iack_out, vme_write_out};
					{am, va} = {vme_am_out, vme_addr_out};
					`CHK(vme_size_out, loc_size_in)
				end
				rf |= rmw_cycle_flag_out === 1;
				irq |= write_err_irq_out === 1;
			end
			ill = a[31:30] != 2'h0;
			ik = a[31:20] == 12'h1DF;
			`CHK(loc_berr_out, ~w & (ill | mute))
			if ((~w | r) & ~ill & ~mute & ~ik & loc_size_in == 2)
				`CHK(loc_rdata_out, xva(a) ^ 32'h5A5A5A5A)
			loc_req_in = 0;
			@(posedge core_clk_in);
			#1;
			irq |= write_err_irq_out === 1;
			`CHK(irq, w & (ill | mute))
			`CHK(sa, ~ill)
			if (!ill) `CHK(ia, ik)
			if (!ill) `CHK(wr, w & ~r & ~ik)
			if (w & ~ill) `CHK(vme_wdata_out, loc_wdata_in)
			if (!ill && !ik) `CHK({am, va}, {xam(a), xva(a)})
			if (ik) `CHK(va, {29'h0, a[3:1]})
			if (r) `CHK(rf, 1'b1)
			$display("master %h done", a);
		end
	endtask
	task s(input [31:0] a, input [5:0] am, input al, w, input [1:0] e);
		integer i;
		reg mw;
		reg [31:0] ma, xl;
		begin
			@(posedge core_clk_in);
			#1;
			{slv_addr_in, slv_am_in, slv_aligned_in, slv_write_in} = {a, am, al, w};
			slv_as_in = 1;
			{mw, ma} = {33{1'bx}};
			xl = !am[5] ? {4'h0, a[27:0]} : !a[23] ? {8'h00, a[23:0]} :
				{6'h00, a24_window_in, 2'h0, a[21:0]};
			for (i = 0; i < 80 && slv_dtack_out !== 1 &&
			     slv_berr_out !== 1; i++) begin
				@(posedge core_clk_in);
				#1;
				if (mem_req_out === 1 && gdma_grant_out !== 1)
					{mw, ma} = {mem_write_out, mem_addr_out};
			end
			`CHK({slv_berr_out, slv_dtack_out}, e)
			if (e == 2'h1) `CHK({mw, ma}, {w, xl})
			slv_as_in = 0;
			for (i = 0; i < 20 && (slv_dtack_out | slv_berr_out) !== 0; i++)
				@(posedge core_clk_in);
			$display("slave %h done", a);
		end
	endtask
	task g(input d, b, e);
		@(posedge core_clk_in);
		#1;
		{arbiter_disable_in, vme_bbsy_in, vme_br3_bus_in} = {d, b, 1'b1};
		repeat (6) @(posedge core_clk_in);
		#1;
		`CHK(vme_bg3_out, e)
		{arbiter_disable_in, vme_bbsy_in, vme_br3_bus_in} = 3'h0;
		repeat (6) @(posedge core_clk_in);
	endtask
	// ==========================================================
	// Main sequence
	initial begin
		repeat (3) @(posedge core_clk_in);
		#1 rst_in = 0;
		m(32'h10000000, 0, 0);
		m(32'h1BFFFFFC, 1, 0);
		m(32'h1C000000, 0, 0);
		m(32'h1CFFFFFC, 1, 1);
		m(32'h1E000004, 0, 0);
		m(32'h1D000000, 0, 0);
		m(32'h1D1FFFFC, 1, 0);
		m(32'h1D200000, 0, 0);
		m(32'h1DEFFFF0, 0, 0);
		m(32'h1DF00006, 0, 0);
		m(32'h2FFFFFFC, 0, 0);
		m(32'h30000000, 1, 0);
		m(32'h40000000, 0, 0);
		m(32'hFFFFFFFC, 1, 0);
		slow = 1;
		m(32'h10000040, 0, 0);
		{slow, mute} = 2'h1;
		m(32'h10000080, 0, 0);
		m(32'h10000080, 1, 0);
		mute = 0;
		s(32'h50000100, 6'h09, 1, 0, 1);
		s(32'h5000FF00, 6'h0D, 1, 1, 1);
		s(32'hD0000100, 6'h09, 1, 0, 0);
		s(32'h40000100, 6'h09, 1, 0, 0);
		s(32'h50000200, 6'h0B, 1, 0, 1);
		s(32'h50000300, 6'h09, 0, 0, 0);
		s(32'h00000100, 6'h3D, 1, 0, 1);
		s(32'h007FFF00, 6'h3B, 1, 1, 1);
		s(32'h00900000, 6'h3D, 1, 0, 0);
		s(32'h57000000, 6'h09, 1, 0, 2);
		a24_window_in = 2'h1;
		s(32'h00C00100, 6'h39, 1, 0, 1);
		a24_disable_switch_in = 1;
		s(32'h00000100, 6'h3D, 1, 0, 0);
		{a24_disable_switch_in, vme_slave_enable_in} = 2'h0;
		s(32'h50000100, 6'h09, 1, 0, 0);
		vme_slave_enable_in = 1;
		g(0, 0, 1);
		g(0, 1, 0);
		g(1, 0, 0);
		give_verdict;
	end
endmodule
